// ==== inc/btb_defs.svh ====
`ifndef BTB_DEFS_SVH
`define BTB_DEFS_SVH

// ==========================================================
// address fields
`define BTB_SET_HI 6
`define BTB_SET_LO 2
`define BTB_TAG_HI 20
`define BTB_TAG_LO 7
`define BTB_SLOT_HI 1
`define BTB_ADDR_W 21
`define BTB_TAG_W 16
`define BTB_TAG_CMP_LO 2

// ==========================================================
// replacement state after reset or flush: way n has age n
`define BTB_LRU_INIT 8'he4

// ==========================================================
// stall cycle counts
`define BTB_PEN_NONE 4'h0
`define BTB_PEN_MISS 4'h4
`define BTB_PEN_INT 4'h5
`define BTB_PEN_COMP 4'ha
`define BTB_PEN_CROSS 4'h1

`endif

// ==== inc/btb_pkg.sv ====
// ==========================================================
// types shared by the branch target buffer
package btb_pkg;

	// loop counter condition stored with an entry
	typedef enum logic [2:0] {
		btb_lc_none = 3'h0,
		btb_lc_l0e = 3'h1,
		btb_lc_l1e = 3'h2,
		btb_lc_nl0e = 3'h3,
		btb_lc_nl1e = 3'h4
	} btb_loop_type;

	// pipeline step at which fetch is redirected
	typedef enum logic [3:0] {
		btb_st_f1f2 = 4'h1,
		btb_st_pdd = 4'h2,
		btb_st_di = 4'h4,
		btb_st_e1e2 = 4'h8
	} btb_stage_type;

endpackage

// ==== rtl/btb_lru.sv ====
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// age based replacement for one set: age 0 is most recent
module btb_lru #(
	parameter int WAYS = 4,
	parameter int AW = 2
) (
	input wire logic [WAYS*AW-1:0] ages,
	input wire logic [AW-1:0] touch,
	input wire logic [WAYS-1:0] valid_mask,
	input wire logic [WAYS-1:0] lock_mask,
	output logic [WAYS*AW-1:0] new_ages,
	output logic [AW-1:0] victim,
	output logic victim_ok
);

	logic [AW-1:0] old_age;
	assign old_age = ages[touch*AW +: AW];

	// touched way becomes newest, younger ways grow older
	always_comb begin
		for (int i = 0; i < WAYS; i++) begin
			if (AW'(i) == touch) begin
				new_ages[i*AW +: AW] = '0;
			end else if (ages[i*AW +: AW] < old_age) begin
				new_ages[i*AW +: AW] = ages[i*AW +: AW] + AW'(1);
			end else begin
				new_ages[i*AW +: AW] = ages[i*AW +: AW];
			end
		end
	end

	// empty way first, else the oldest way that is not locked
	always_comb begin
		logic [AW-1:0] best;
		logic found;
		logic empty;
		best = '0;
		found = 1'b0;
		empty = 1'b0;
		for (int i = WAYS - 1; i >= 0; i--) begin
			if (!valid_mask[i]) begin
				best = AW'(i);
				empty = 1'b1;
			end
		end
		if (!empty) begin
			for (int i = 0; i < WAYS; i++) begin
				if (!lock_mask[i] &&
					(!found || ages[i*AW +: AW] > ages[best*AW +: AW])) begin
					best = AW'(i);
					found = 1'b1;
				end
			end
		end
		victim = best;
		victim_ok = empty | found;
	end

endmodule

`default_nettype wire

// ==== rtl/btb_penalty.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "btb_defs.svh"

// ==========================================================
// stall cost and redirect step of one resolved branch
module btb_penalty
	import btb_pkg::*;
(
	input wire logic predicted,
	input wire logic hit,
	input wire logic taken,
	input wire logic compute,
	input wire logic cross_qw,
	output logic [3:0] cycles,
	output btb_stage_type stage
);

	logic [3:0] base;
	logic [3:0] extra;
	btb_stage_type late;

	// condition resolves at integer or second execute step
	assign late = compute ? btb_st_e1e2 : btb_st_di;

	always_comb begin
		if (predicted && taken) begin
			// R18: hit costs nothing
			// R19: miss redirects at predecode
			base = hit ? `BTB_PEN_NONE : `BTB_PEN_MISS;
			stage = hit ? btb_st_f1f2 : btb_st_pdd;
		end else if (!predicted && !taken) begin
			// R20: sequential fetch, no stall
			base = `BTB_PEN_NONE;
			stage = late;
		end else begin
			// R21: mispredict by condition source
			base = compute ? `BTB_PEN_COMP : `BTB_PEN_INT;
			stage = late;
		end
	end

	// R22: quad word crossing adds one
	assign extra = cross_qw ? `BTB_PEN_CROSS : `BTB_PEN_NONE;
	assign cycles = base + extra;

endmodule

`default_nettype wire

// ==== rtl/btb_top.sv ====
// What this block does
// R1: hits only while enabled, else miss
// R2: entry holds line-end tag and target
// R3: compare fetched quad word, report hit/miss
// R4: hit supplies stored target as next fetch
// R5: indirect target from jump or return register
// R6: software preloads indirect register, else penalty
// R7: loop entries hit when expiry matches condition
// R8: 128 entries, 4 ways, LRU skips locked
// R9: lock mode locks added or accessed entries
// R10: invalidate clears every entry, locked too
// R11: internal only, 21-bit targets, one per quad
// R12: set index is address bits 6 to 2
// R13: tag is address bits 20-7 and 1-0
// R14: target field is bits 20 to 0
// R15: valid, jump, return, absolute, lock flags
// R16: per-set LRU field picks the victim way
// R17: not-predicted branches never hit or allocate
// R18: hit redirects at first to second fetch
// R19: miss redirects at predecode, four stalls
// R20: not-predicted waits for condition, no stall
// R21: mispredict costs five or ten cycles
// R22: quad word crossing adds one cycle
// R23: predicted miss writes target into buffer
// R24: hit or allocation makes way most recent; a hit is not recorded when an allocation writes the same set that cycle
`timescale 1ns/1ps
`default_nettype none
`include "btb_defs.svh"

module btb_top
	import btb_pkg::*;
#(
	parameter int SETS = 32,
	parameter int WAYS = 4
) (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic predictor_enable_instr,
	input wire logic predictor_disable_instr,
	input wire logic lock_start_instr,
	input wire logic lock_stop_instr,
	input wire logic invalidate_all_instr,
	input wire logic fetch_valid,
	input wire logic fetch_internal,
	input wire logic [`BTB_ADDR_W-1:0] fetch_addr,
	input wire logic loop0_expire_pred,
	input wire logic loop1_expire_pred,
	input wire logic [`BTB_ADDR_W-1:0] computed_jump_reg,
	input wire logic [`BTB_ADDR_W-1:0] interrupt_return_reg,
	input wire logic alloc_valid,
	input wire logic alloc_internal,
	input wire logic alloc_not_predicted,
	input wire logic [`BTB_ADDR_W-1:0] alloc_line_end_addr,
	input wire logic [`BTB_ADDR_W-1:0] alloc_target,
	input wire logic alloc_computed_jump,
	input wire logic alloc_interrupt_return,
	input wire logic alloc_absolute,
	input wire btb_loop_type alloc_loop_cond,
	input wire logic alloc_is_jump,
	input wire logic br_valid,
	input wire logic br_not_predicted,
	input wire logic br_hit,
	input wire logic br_taken,
	input wire logic br_compute,
	input wire logic br_cross_qw,
	output logic fetch_hit,
	output logic fetch_miss,
	output logic [`BTB_ADDR_W-1:0] next_fetch_addr,
	output logic [`BTB_SLOT_HI:0] hit_line_slot,
	output logic hit_absolute,
	output logic hit_indirect,
	output logic penalty_valid,
	output logic [3:0] penalty_cycles,
	output logic [3:0] penalty_stage,
	output logic predictor_enabled,
	output logic locking_active
);

	localparam int WB = $clog2(WAYS);
	localparam int SB = $clog2(SETS);
	localparam int EB = WB + SB;
	localparam int ENT = SETS * WAYS;
	localparam int LW = WAYS * WB;

	// ======================================================
	// entry storage
	logic [`BTB_TAG_W-1:0] tag_mem [0:ENT-1];
	logic [`BTB_ADDR_W-1:0] tgt_mem [0:ENT-1];
	btb_loop_type lc_mem [0:ENT-1];
	logic [ENT-1:0] cj_mem;
	logic [ENT-1:0] ri_mem;
	logic [ENT-1:0] ab_mem;
	logic [ENT-1:0] jp_mem;
	logic [ENT-1:0] valid_r;
	logic [ENT-1:0] lock_r;
	logic [LW-1:0] lru_r [0:SETS-1];

	// ======================================================
	// control and output registers
	logic enable_r;
	logic locking_r;
	logic hit_r;
	logic miss_r;
	logic [`BTB_ADDR_W-1:0] nfa_r;
	logic [`BTB_SLOT_HI:0] slot_r;
	logic abs_r;
	logic ind_r;
	logic pen_v_r;
	logic [3:0] pen_c_r;
	logic [3:0] pen_s_r;

	// loop counter condition against predicted expiry
	function automatic logic loop_ok(btb_loop_type lc,
		logic p0, logic p1);
		unique case (lc)
			btb_lc_none: loop_ok = 1'b1;
			btb_lc_l0e: loop_ok = p0;
			btb_lc_l1e: loop_ok = p1;
			btb_lc_nl0e: loop_ok = !p0;
			btb_lc_nl1e: loop_ok = !p1;
			default: loop_ok = 1'b0;
		endcase
	endfunction

	// ======================================================
	// lookup side
	// R12: set from bits 6 to 2
	wire [SB-1:0] lk_set = fetch_addr[`BTB_SET_HI:`BTB_SET_LO];
	wire [WAYS-1:0] lk_match;
	wire [WAYS-1:0] wr_match;
	wire [WAYS-1:0] wr_vmask;
	wire [WAYS-1:0] wr_lmask;
	wire [SB-1:0] wr_set =
		alloc_line_end_addr[`BTB_SET_HI:`BTB_SET_LO];

	genvar w;
	generate
		for (w = 0; w < WAYS; w++) begin : g_way
			wire [EB-1:0] li = {lk_set, WB'(w)};
			wire [EB-1:0] wi = {wr_set, WB'(w)};
			// R13: compare bits 20-7 of the quad word
			// R7: loop entries need matching expiry and jump
			assign lk_match[w] = valid_r[li] && jp_mem[li] &&
				tag_mem[li][`BTB_TAG_W-1:`BTB_TAG_CMP_LO] ==
				fetch_addr[`BTB_TAG_HI:`BTB_TAG_LO] &&
				loop_ok(lc_mem[li], loop0_expire_pred,
				loop1_expire_pred);
			// R11: one tag per aligned quad word
			assign wr_match[w] = valid_r[wi] &&
				tag_mem[wi][`BTB_TAG_W-1:`BTB_TAG_CMP_LO] ==
				alloc_line_end_addr[`BTB_TAG_HI:`BTB_TAG_LO];
			assign wr_vmask[w] = valid_r[wi];
			assign wr_lmask[w] = lock_r[wi];
		end
	endgenerate

	// hit way, lowest index wins if several match
	logic [WB-1:0] lk_way;
	logic [WB-1:0] wm_way;
	always_comb begin
		lk_way = '0;
		wm_way = '0;
		for (int i = WAYS - 1; i >= 0; i--) begin
			if (lk_match[i]) begin
				lk_way = WB'(i);
			end
			if (wr_match[i]) begin
				wm_way = WB'(i);
			end
		end
	end

	// R1: no hit while disabled
	// R3: internal fetch with a matching way hits
	wire lk_look = fetch_valid && fetch_internal;
	wire lk_hit = lk_look && enable_r && (|lk_match);
	wire [EB-1:0] lk_idx = {lk_set, lk_way};

	// R5: indirect entries take a register as target
	// R4: otherwise the stored target
	wire [`BTB_ADDR_W-1:0] lk_tgt =
		cj_mem[lk_idx] ? computed_jump_reg :
		ri_mem[lk_idx] ? interrupt_return_reg :
		tgt_mem[lk_idx];

	// ======================================================
	// allocation side
	logic [LW-1:0] wr_new;
	logic [LW-1:0] lk_new;
	logic [WB-1:0] victim;
	logic victim_ok;
	logic [WB-1:0] wr_way;

	// R16: per-set ages choose the victim
	// R8: locked ways are never chosen
	btb_lru #(.WAYS(WAYS), .AW(WB)) u_wr_lru (
		.ages(lru_r[wr_set]),
		.touch(wr_way),
		.valid_mask(wr_vmask),
		.lock_mask(wr_lmask),
		.new_ages(wr_new),
		.victim(victim),
		.victim_ok(victim_ok)
	);

	btb_lru #(.WAYS(WAYS), .AW(WB)) u_lk_lru (
		.ages(lru_r[lk_set]),
		.touch(lk_way),
		.valid_mask({WAYS{1'b1}}),
		.lock_mask({WAYS{1'b0}}),
		.new_ages(lk_new),
		.victim(),
		.victim_ok()
	);

	// same quad word reuses its way, else take the victim
	wire wr_same = |wr_match;
	assign wr_way = wr_same ? wm_way : victim;
	wire [EB-1:0] wr_idx = {wr_set, wr_way};
	wire wr_room = wr_same ? !lock_r[wr_idx] : victim_ok;
	// R17: not-predicted branches never enter
	// R23: predicted miss writes the entry
	wire wr_go = alloc_valid && alloc_internal && enable_r &&
		!alloc_not_predicted && wr_room && !invalidate_all_instr;
	wire lk_upd = lk_hit && !invalidate_all_instr;

	// ======================================================
	// mode flags
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			enable_r <= 1'b0;
			locking_r <= 1'b0;
		end else begin
			if (predictor_enable_instr) begin
				enable_r <= 1'b1;
			end else if (predictor_disable_instr) begin
				enable_r <= 1'b0;
			end
			if (lock_start_instr) begin
				locking_r <= 1'b1;
			end else if (lock_stop_instr) begin
				locking_r <= 1'b0;
			end
		end
	end

	// ======================================================
	// valid and lock flags
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			valid_r <= '0;
			lock_r <= '0;
		end else if (invalidate_all_instr) begin
			// R10: flush clears locked entries too
			valid_r <= '0;
			lock_r <= '0;
		end else begin
			// R9: lock mode marks written entries
			if (wr_go) begin
				valid_r[wr_idx] <= 1'b1;
				lock_r[wr_idx] <= locking_r;
			end
			// R9: lock mode marks accessed entries
			if (lk_upd && locking_r) begin
				lock_r[lk_idx] <= 1'b1;
			end
		end
	end

	// ======================================================
	// entry fields, written on allocation
	always_ff @(posedge clock) begin
		if (wr_go) begin
			// R2: tag from line end address
			// R13: bits 20-7 and 1-0
			tag_mem[wr_idx] <= {
				alloc_line_end_addr[`BTB_TAG_HI:`BTB_TAG_LO],
				alloc_line_end_addr[`BTB_SLOT_HI:0]};
			// R14: full 21-bit target
			tgt_mem[wr_idx] <= alloc_target;
			// R15: per-entry flags
			cj_mem[wr_idx] <= alloc_computed_jump;
			ri_mem[wr_idx] <= alloc_interrupt_return;
			ab_mem[wr_idx] <= alloc_absolute;
			jp_mem[wr_idx] <= alloc_is_jump;
			lc_mem[wr_idx] <= alloc_loop_cond;
		end
	end

	// ======================================================
	// replacement ages
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			for (int s = 0; s < SETS; s++) begin
				lru_r[s] <= LW'(`BTB_LRU_INIT);
			end
		end else if (invalidate_all_instr) begin
			for (int s = 0; s < SETS; s++) begin
				lru_r[s] <= LW'(`BTB_LRU_INIT);
			end
		end else begin
			// R24: touched way becomes most recent; an allocation to the same set in the same cycle drops the hit's update
			if (wr_go) begin
				lru_r[wr_set] <= wr_new;
			end
			if (lk_upd && !(wr_go && wr_set == lk_set)) begin
				lru_r[lk_set] <= lk_new;
			end
		end
	end

	// ======================================================
	// lookup answer, one cycle after the request
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			hit_r <= 1'b0;
			miss_r <= 1'b0;
			nfa_r <= '0;
			slot_r <= '0;
			abs_r <= 1'b0;
			ind_r <= 1'b0;
		end else begin
			// R18: redirect as the line leaves first fetch
			hit_r <= lk_hit;
			miss_r <= lk_look && !lk_hit;
			if (lk_hit) begin
				nfa_r <= lk_tgt;
				slot_r <= tag_mem[lk_idx][`BTB_SLOT_HI:0];
				abs_r <= ab_mem[lk_idx];
				// R6: sequencer rechecks indirect targets
				ind_r <= cj_mem[lk_idx] | ri_mem[lk_idx];
			end
		end
	end

	// ======================================================
	// branch cost
	logic [3:0] pen_c;
	btb_stage_type pen_s;

	btb_penalty u_pen (
		.predicted(!br_not_predicted),
		.hit(br_hit && !br_not_predicted),
		.taken(br_taken),
		.compute(br_compute),
		.cross_qw(br_cross_qw),
		.cycles(pen_c),
		.stage(pen_s)
	);

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			pen_v_r <= 1'b0;
			pen_c_r <= `BTB_PEN_NONE;
			pen_s_r <= '0;
		end else begin
			pen_v_r <= br_valid;
			if (br_valid) begin
				pen_c_r <= pen_c;
				pen_s_r <= pen_s;
			end
		end
	end

	// ======================================================
	// outputs
	assign fetch_hit = hit_r;
	assign fetch_miss = miss_r;
	assign next_fetch_addr = nfa_r;
	assign hit_line_slot = slot_r;
	assign hit_absolute = abs_r;
	assign hit_indirect = ind_r;
	assign penalty_valid = pen_v_r;
	assign penalty_cycles = pen_c_r;
	assign penalty_stage = pen_s_r;
	assign predictor_enabled = enable_r;
	assign locking_active = locking_r;

endmodule

`default_nettype wire

// ==== tb/btb_seq_model.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "btb_defs.svh"

// ==========================================================
// sequencer side: indirect target registers written by software
module btb_seq_model (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic ld_jump,
	input wire logic ld_ret,
	input wire logic [`BTB_ADDR_W-1:0] ld_value,
	output logic [`BTB_ADDR_W-1:0] computed_jump_reg,
	output logic [`BTB_ADDR_W-1:0] interrupt_return_reg
);
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			computed_jump_reg <= 21'h0;
			interrupt_return_reg <= 21'h0;
		end else begin
			if (ld_jump) computed_jump_reg <= ld_value;
			if (ld_ret) interrupt_return_reg <= ld_value;
		end
	end
endmodule
`default_nettype wire

// ==== tb/btb_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "btb_defs.svh"

// ==========================================================
// port level checks of the branch target buffer
module btb_monitor (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic predictor_enable_instr,
	input wire logic lock_start_instr,
	input wire logic invalidate_all_instr,
	input wire logic fetch_valid,
	input wire logic fetch_internal,
	input wire logic br_valid,
	input wire logic br_not_predicted,
	input wire logic br_hit,
	input wire logic br_taken,
	input wire logic br_compute,
	input wire logic br_cross_qw,
	input wire logic fetch_hit,
	input wire logic fetch_miss,
	input wire logic [`BTB_ADDR_W-1:0] next_fetch_addr,
	input wire logic penalty_valid,
	input wire logic [3:0] penalty_cycles,
	input wire logic [3:0] penalty_stage,
	input wire logic predictor_enabled,
	input wire logic locking_active
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!arst_n);

	// ==========================================================
	// lookup side
	hit_needs_enable_a: assert property (
		fetch_hit |-> $past(predictor_enabled))
		else $error("hit while lookups disabled");
	enable_on_a: assert property (
		predictor_enable_instr |=> predictor_enabled)
		else $error("enable did not take");
	lookup_answer_a: assert property (
		fetch_valid && fetch_internal |=> fetch_hit ^ fetch_miss)
		else $error("lookup gave no single answer");
	external_quiet_a: assert property (
		!(fetch_valid && fetch_internal) |=> !fetch_hit && !fetch_miss)
		else $error("answer without internal lookup");
	target_held_a: assert property (
		!fetch_hit |-> $stable(next_fetch_addr))
		else $error("fetch target moved without hit");
	flush_miss_a: assert property (
		invalidate_all_instr ##1 fetch_valid |=> !fetch_hit)
		else $error("hit after invalidate");
	lock_on_a: assert property (
		lock_start_instr |=> locking_active)
		else $error("lock mode did not start");

	// ==========================================================
	// branch cost side
	pen_pulse_a: assert property (
		br_valid ##1 !br_valid |-> penalty_valid ##1 !penalty_valid)
		else $error("penalty strobe wrong");
	pen_hit_a: assert property (
		br_valid && !br_not_predicted && br_hit && br_taken |=>
		penalty_cycles == {3'h0, $past(br_cross_qw)} &&
		penalty_stage == 4'h1)
		else $error("hit cost wrong");
	pen_miss_a: assert property (
		br_valid && !br_not_predicted && !br_hit && br_taken |=>
		penalty_cycles == 4'h4 + $past(br_cross_qw) &&
		penalty_stage == 4'h2)
		else $error("miss cost wrong");
	pen_wrong_a: assert property (
		br_valid && (br_not_predicted == br_taken) |=>
		penalty_cycles == ($past(br_compute) ? 4'ha : 4'h5) +
		$past(br_cross_qw) &&
		penalty_stage == ($past(br_compute) ? 4'h8 : 4'h4))
		else $error("mispredict cost wrong");
	np_free_a: assert property (
		br_valid && br_not_predicted && !br_taken |=>
		penalty_cycles == {3'h0, $past(br_cross_qw)})
		else $error("not-predicted cost wrong");

	// ==========================================================
	// main scenarios seen
	cover property (fetch_hit);
	cover property (br_valid && br_compute && !br_taken);
	cover property (invalidate_all_instr ##1 fetch_valid);
endmodule

bind btb_top btb_monitor mon (.*);
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "btb_defs.svh"

module tb_top
	import btb_pkg::*;
;
	// ==========================================================
	// stimulus and observed nets
	logic clock, arst_n, predictor_enable_instr, predictor_disable_instr;
	logic lock_start_instr, lock_stop_instr, invalidate_all_instr;
	logic fetch_valid, fetch_internal, loop0_expire_pred, loop1_expire_pred;
	logic alloc_valid, alloc_internal, alloc_not_predicted, alloc_is_jump;
	logic alloc_computed_jump, alloc_interrupt_return, alloc_absolute;
	logic br_valid, br_not_predicted, br_hit, br_taken, br_compute;
	logic br_cross_qw, ld_jump, ld_ret;
	logic [20:0] fetch_addr, alloc_line_end_addr, alloc_target, ld_value;
	btb_loop_type alloc_loop_cond;
	wire logic [20:0] computed_jump_reg, interrupt_return_reg;
	wire logic [20:0] next_fetch_addr;
	wire logic fetch_hit, fetch_miss, hit_absolute, hit_indirect;
	wire logic penalty_valid, predictor_enabled, locking_active;
	wire logic [1:0] hit_line_slot;
	wire logic [3:0] penalty_cycles, penalty_stage;
	int fails, check_count;

	btb_top uut (.*);
	btb_seq_model partner (.*);

	// ==========================================================
	// clock
	initial begin
		clock = 1'h0;
		forever #4 clock = ~clock;
	end

	// ==========================================================
	// helpers
	task automatic tick(int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	task automatic chk(logic [20:0] got, logic [20:0] exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	function automatic logic [20:0] qa(logic [13:0] t, logic [4:0] s);
		return {t, s, 2'h0};
	endfunction

	task automatic look(logic [20:0] a, logic h, logic [20:0] t);
		fetch_addr = a;
		fetch_valid = 1'h1;
		tick(1);
		fetch_valid = 1'h0;
		chk(fetch_hit, h);
		chk(fetch_miss, !h);
		if (h) chk(next_fetch_addr, t);
		tick(1);
	endtask

	task automatic wr(logic [20:0] a, logic [20:0] t, logic [3:0] f);
		alloc_line_end_addr = a;
		alloc_target = t;
		{alloc_absolute, alloc_interrupt_return, alloc_computed_jump,
			alloc_not_predicted} = f;
		alloc_valid = 1'h1;
		tick(1);
		alloc_valid = 1'h0;
		tick(1);
	endtask

	task automatic br(logic [4:0] f, logic [3:0] c, logic [3:0] s);
		{br_not_predicted, br_hit, br_taken, br_compute, br_cross_qw} = f;
		br_valid = 1'h1;
		tick(1);
		br_valid = 1'h0;
		chk(penalty_valid, 1'h1);
		chk(penalty_cycles, c);
		if (s != 4'h0) chk(penalty_stage, s);
		tick(1);
	endtask

	task automatic pulse(ref logic x);
		x = 1'h1;
		tick(1);
		x = 1'h0;
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// ==========================================================
	// main sequence
	initial begin
		{predictor_enable_instr, predictor_disable_instr, lock_start_instr,
			lock_stop_instr, invalidate_all_instr, fetch_valid,
			loop0_expire_pred, loop1_expire_pred, alloc_valid,
			alloc_not_predicted, alloc_computed_jump, alloc_interrupt_return,
			alloc_absolute, br_valid, br_not_predicted, br_hit, br_taken,
			br_compute, br_cross_qw, ld_jump, ld_ret} = 21'h0;
		{fetch_internal, alloc_internal, alloc_is_jump} = 3'h7;
		{fetch_addr, alloc_line_end_addr, alloc_target, ld_value} = 84'h0;
		alloc_loop_cond = btb_lc_none;
		fails = 0;
		check_count = 0;
		arst_n = 1'h0;
		repeat (20) @(posedge clock);
		#1;
		arst_n = 1'h1;
		chk(predictor_enabled, 1'h0);
		chk(locking_active, 1'h0);
		wr(qa(14'h1, 5'h3), 21'h1abcd, 4'h0);
		look(qa(14'h1, 5'h3), 1'h0, 21'h0);
		$display("test disabled done");
		pulse(predictor_enable_instr);
		chk(predictor_enabled, 1'h1);
		wr(qa(14'h1, 5'h3) | 21'h2, 21'h1abcd, 4'h0);
		look(qa(14'h1, 5'h3), 1'h1, 21'h1abcd);
		chk(hit_line_slot, 2'h2);
		chk({hit_absolute, hit_indirect}, 21'h0);
		look(qa(14'h2, 5'h3), 1'h0, 21'h0);
		alloc_internal = 1'h0;
		wr(qa(14'h5, 5'h3), 21'h5, 4'h0);
		alloc_internal = 1'h1;
		wr(qa(14'h6, 5'h3), 21'h6, 4'h1);
		look(qa(14'h5, 5'h3), 1'h0, 21'h0);
		look(qa(14'h6, 5'h3), 1'h0, 21'h0);
		fetch_internal = 1'h0;
		fetch_addr = qa(14'h1, 5'h3);
		fetch_valid = 1'h1;
		tick(1);
		fetch_valid = 1'h0;
		fetch_internal = 1'h1;
		chk(fetch_hit | fetch_miss, 1'h0);
		$display("test basic done");
		ld_value = 21'h0f0f0;
		pulse(ld_jump);
		ld_value = 21'h15555;
		pulse(ld_ret);
		wr(qa(14'h1, 5'h4), 21'h1, 4'h2);
		look(qa(14'h1, 5'h4), 1'h1, 21'h0f0f0);
		chk(hit_indirect, 1'h1);
		wr(qa(14'h1, 5'h5), 21'h1, 4'hc);
		look(qa(14'h1, 5'h5), 1'h1, 21'h15555);
		chk(hit_absolute, 1'h1);
		$display("test indirect done");
		for (int c = 1; c < 5; c++) begin
			alloc_loop_cond = btb_loop_type'(c);
			wr(qa(14'h1, 5'h6), 21'h77, 4'h0);
			{loop1_expire_pred, loop0_expire_pred} =
				(c == 1 || c == 4) ? 2'h1 : 2'h2;
			look(qa(14'h1, 5'h6), 1'h1, 21'h77);
			{loop1_expire_pred, loop0_expire_pred} =
				(c == 1 || c == 4) ? 2'h2 : 2'h1;
			look(qa(14'h1, 5'h6), 1'h0, 21'h0);
		end
		alloc_loop_cond = btb_lc_none;
		alloc_is_jump = 1'h0;
		wr(qa(14'h1, 5'h6), 21'h77, 4'h0);
		look(qa(14'h1, 5'h6), 1'h0, 21'h0);
		alloc_is_jump = 1'h1;
		$display("test loop done");
		for (int i = 0; i < 4; i++) wr(qa(14'(i + 1), 5'h7), 21'(i), 4'h0);
		look(qa(14'h1, 5'h7), 1'h1, 21'h0);
		wr(qa(14'h5, 5'h7), 21'h5, 4'h0);
		look(qa(14'h2, 5'h7), 1'h0, 21'h0);
		look(qa(14'h1, 5'h7), 1'h1, 21'h0);
		look(qa(14'h5, 5'h7), 1'h1, 21'h5);
		$display("test replace done");
		pulse(lock_start_instr);
		chk(locking_active, 1'h1);
		wr(qa(14'h1, 5'h9), 21'h99, 4'h0);
		pulse(lock_stop_instr);
		chk(locking_active, 1'h0);
		for (int i = 2; i < 7; i++) wr(qa(14'(i), 5'h9), 21'(i), 4'h0);
		look(qa(14'h1, 5'h9), 1'h1, 21'h99);
		pulse(predictor_disable_instr);
		look(qa(14'h1, 5'h9), 1'h0, 21'h0);
		pulse(predictor_enable_instr);
		pulse(invalidate_all_instr);
		look(qa(14'h1, 5'h9), 1'h0, 21'h0);
		// a hit in lock mode locks the entry
		wr(qa(14'h1, 5'ha), 21'haa, 4'h0);
		pulse(lock_start_instr);
		look(qa(14'h1, 5'ha), 1'h1, 21'haa);
		pulse(lock_stop_instr);
		for (int i = 2; i < 7; i++) wr(qa(14'(i), 5'ha), 21'(i), 4'h0);
		look(qa(14'h1, 5'ha), 1'h1, 21'haa);
		$display("test lock done");
		br(5'b01100, 4'h0, 4'h1);
		br(5'b01101, 4'h1, 4'h1);
		br(5'b00100, 4'h4, 4'h2);
		br(5'b00000, 4'h5, 4'h4);
		br(5'b00010, 4'ha, 4'h8);
		br(5'b10100, 4'h5, 4'h4);
		br(5'b10111, 4'hb, 4'h8);
		br(5'b10000, 4'h0, 4'h4);
		br(5'b11001, 4'h1, 4'h4);
		$display("test penalty done");
		end_of_test();
	end
endmodule
`default_nettype wire
